// File: include/secp_defs.vh
// constants for the serial eeprom command port
// assumes a 10 MHz clock and a plain strobe register port
// How it works
// RL1 - writing one to the busy bit starts the chosen command at the address
// RL2 - busy stays set until done, then self-clears; host leaves registers alone
// RL3 - write with no eeprom present keeps busy until timeout, then clears
// RL4 - code 000 reads, 011 writes, 111 reloads; other codes are reserved
// RL5 - read fetches the addressed byte into the data register
// RL6 - write stores the data byte at the addressed eeprom location
// RL7 - reload with no valid content fails and leaves loaded flag clear
// RL8 - after reload the device is not ready until loading ends
// RL9 - overflow flag sets when the loader reads past the last location
// RL10 - overflow flag clears on every loader restart, reload or reset
// RL11 - timeout flag sets when a write gets no completion within 30 ms
// RL12 - timeout also on missing acks, long clock stretch, no bus, bad command
// RL13 - timeout flag resets to zero and clears only on a written one
// RL14 - loaded flag sets only after a valid eeprom loads without error
// RL15 - loaded flag clears on reset and at the start of every reload
// RL16 - writing one to the loaded flag position clears it
// RL17 - 16-bit address field picks the location and resets to zero
// RL18 - data byte in bits 7:0, resets to zero, upper bits read zero
`ifndef SECP_DEFS_VH
`define SECP_DEFS_VH

`define SECP_AW             12
`define SECP_OFF_CMD        12'h1B4
`define SECP_OFF_DATA       12'h1B8
`define SECP_OFF_ISTAT      12'h1BC
`define SECP_OFF_IMASK      12'h1C0

`define SECP_BIT_BUSY       31
`define SECP_CMD_HI         30
`define SECP_CMD_LO         28
`define SECP_BIT_OVF        18
`define SECP_BIT_TMO        17
`define SECP_BIT_LOADED     16
`define SECP_ADDR_HI        15

`define SECP_OP_READ        3'h0
`define SECP_OP_WRITE       3'h3
`define SECP_OP_RELOAD      3'h7

`define SECP_RST_ADDR       16'h0000
`define SECP_RST_DATA       8'h00
`define SECP_RST_MASK       4'h0

`define SECP_IRQ_DONE       0
`define SECP_IRQ_TMO        1
`define SECP_IRQ_LOADED     2
`define SECP_IRQ_OVF        3

// 30 ms and 1.92 s counted at 10 MHz, sized to the timer width
`define SECP_T_WR_CYC       25'd300000
`define SECP_T_ACQ_CYC      25'd19200000
`define SECP_TW             25

`endif

// File: rtl/secp_eeprom_port.v
// command and data registers in front of the serial eeprom engine
// assumes the bus engine and config loader run on clk, no sync needed
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ns
`include "secp_defs.vh"
module secp_eeprom_port #(
	parameter [24:0] T_WR_CYC  = `SECP_T_WR_CYC,
	parameter [24:0] T_ACQ_CYC = `SECP_T_ACQ_CYC
) (
	input  wire                    clk,
	input  wire                    rst,
	input  wire [`SECP_AW-1:0]     reg_addr,
	input  wire [31:0]             reg_wdata,
	input  wire                    reg_wr,
	input  wire                    reg_rd,
	output reg  [31:0]             reg_rdata,
	output reg                     irq,
	output reg                     eng_req,
	output reg                     eng_write,
	output reg  [15:0]             eng_addr,
	output reg  [7:0]              eng_wdata,
	input  wire                    eng_gnt,
	input  wire                    eng_done,
	input  wire                    eng_nack,
	input  wire                    eng_scl_low,
	input  wire [7:0]              eng_rdata,
	output reg                     ldr_start,
	input  wire                    ldr_done,
	input  wire                    ldr_ok,
	input  wire                    ldr_overflow,
	output reg                     dev_ready
);
	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_ACQ  = 2'h1;
	localparam [1:0] ST_XFER = 2'h2;
	localparam [1:0] ST_RLD  = 2'h3;

	function sel;
		input [`SECP_AW-1:0] a;
		input [`SECP_AW-1:0] off;
		begin
			sel = (a == off);
		end
	endfunction

	reg [1:0]  state_q;
	reg [1:0]  state_d;
	reg        busy_q;
	reg        busy_d;
	reg [2:0]  cmd_q;
	reg [15:0] addr_q;
	reg [7:0]  data_q;
	reg [7:0]  data_d;
	reg        tmo_q;
	reg        loaded_q;
	reg        ovf_q;
	reg [3:0]  istat_q;
	reg [3:0]  imask_q;
	reg        req_d;
	reg        start_ld;
	reg        ev_done;
	reg        ev_tmo;
	reg        ev_loaded;

	wire wr_cmd   = reg_wr && sel(reg_addr, `SECP_OFF_CMD);
	wire wr_data  = reg_wr && sel(reg_addr, `SECP_OFF_DATA);
	wire wr_mask  = reg_wr && sel(reg_addr, `SECP_OFF_IMASK);
	wire rd_istat = reg_rd && sel(reg_addr, `SECP_OFF_ISTAT);
	wire [2:0] wcmd = reg_wdata[`SECP_CMD_HI:`SECP_CMD_LO];
	wire start    = wr_cmd && reg_wdata[`SECP_BIT_BUSY] && !busy_q; // RL1
	wire wr_tmo;
	wire acq_tmo;

	// write counts the whole transfer; reads only count clock stretch
	wire wr_tmr_en  = (state_q == ST_XFER) && (eng_write || eng_scl_low);
	wire acq_tmr_en = (state_q == ST_ACQ);

	secp_timer #(
		.W     (`SECP_TW),
		.LIMIT (T_WR_CYC)
	) u_wr_tmr (
		.clk     (clk),
		.rst     (rst),
		.en      (wr_tmr_en),
		.expired (wr_tmo)
	); // RL11

	secp_timer #(
		.W     (`SECP_TW),
		.LIMIT (T_ACQ_CYC)
	) u_acq_tmr (
		.clk     (clk),
		.rst     (rst),
		.en      (acq_tmr_en),
		.expired (acq_tmo)
	); // RL12

	always @* begin
		state_d   = state_q;
		busy_d    = busy_q;
		data_d    = data_q;
		req_d     = eng_req;
		start_ld  = 1'b0;
		ev_done   = 1'b0;
		ev_tmo    = 1'b0;
		ev_loaded = 1'b0;
		case (state_q)
		ST_IDLE: begin
			if (start) begin
				case (wcmd) // RL4
				`SECP_OP_READ, `SECP_OP_WRITE: begin
					state_d = ST_ACQ;
					busy_d  = 1'b1; // RL2
					req_d   = 1'b1;
				end
				`SECP_OP_RELOAD: begin
					state_d  = ST_RLD;
					busy_d   = 1'b1;
					start_ld = 1'b1;
				end
				default: begin
					// reserved code: flag it, never go busy
					ev_tmo = 1'b1; // RL12
				end
				endcase
			end
		end
		ST_ACQ: begin
			if (eng_gnt) begin
				state_d = ST_XFER;
				req_d   = 1'b0;
			end else if (acq_tmo) begin
				state_d = ST_IDLE;
				busy_d  = 1'b0;
				req_d   = 1'b0;
				ev_tmo  = 1'b1; // RL12
			end
		end
		ST_XFER: begin
			if (eng_done) begin
				state_d = ST_IDLE;
				busy_d  = 1'b0; // RL2
				if (eng_nack)
					ev_tmo = 1'b1; // RL12
				else begin
					ev_done = 1'b1;
					if (!eng_write)
						data_d = eng_rdata; // RL5
				end
			end else if (wr_tmo) begin
				// absent eeprom on a write ends here (reads only time out on clock stretch), busy drops with the flag
				state_d = ST_IDLE;
				busy_d  = 1'b0; // RL3
				ev_tmo  = 1'b1; // RL11
			end
		end
		ST_RLD: begin
			if (ldr_done) begin
				state_d   = ST_IDLE;
				busy_d    = 1'b0;
				ev_done   = 1'b1;
				ev_loaded = ldr_ok; // RL7 RL14
			end
		end
		default: begin
			state_d = ST_IDLE;
			busy_d  = 1'b0;
		end
		endcase
		// host data writes are ignored while a command runs
		if (wr_data && !busy_q)
			data_d = reg_wdata[7:0];
	end

	always @(posedge clk) begin
		if (rst) begin
			state_q   <= ST_IDLE;
			busy_q    <= 1'b0;
			cmd_q     <= `SECP_OP_READ;
			addr_q    <= `SECP_RST_ADDR; // RL17
			data_q    <= `SECP_RST_DATA; // RL18
			eng_req   <= 1'b0;
			eng_write <= 1'b0;
			eng_addr  <= `SECP_RST_ADDR;
			eng_wdata <= `SECP_RST_DATA;
			ldr_start <= 1'b0;
			dev_ready <= 1'b1;
		end else begin
			state_q   <= state_d;
			busy_q    <= busy_d;
			data_q    <= data_d;
			eng_req   <= req_d;
			ldr_start <= start_ld;
			// command and address frozen while busy
			if (wr_cmd && !busy_q) begin
				cmd_q  <= wcmd;
				addr_q <= reg_wdata[`SECP_ADDR_HI:0];
			end
			if (start) begin
				eng_write <= (wcmd == `SECP_OP_WRITE);
				eng_addr  <= reg_wdata[`SECP_ADDR_HI:0]; // RL17
				eng_wdata <= data_q; // RL6
			end
			if (start_ld)
				dev_ready <= 1'b0; // RL8
			else if (state_q == ST_RLD && ldr_done)
				dev_ready <= 1'b1; // RL8
		end
	end

	// sticky flags; a hardware set beats a same-cycle clear
	always @(posedge clk) begin
		if (rst) begin
			tmo_q    <= 1'b0; // RL13
			loaded_q <= 1'b0; // RL15
			ovf_q    <= 1'b0; // RL10
		end else begin
			if (ev_tmo)
				tmo_q <= 1'b1; // RL11
			else if (wr_cmd && reg_wdata[`SECP_BIT_TMO])
				tmo_q <= 1'b0; // RL13
			if (ev_loaded)
				loaded_q <= 1'b1; // RL14
			else if (start_ld)
				loaded_q <= 1'b0; // RL15
			else if (wr_cmd && reg_wdata[`SECP_BIT_LOADED])
				loaded_q <= 1'b0; // RL16
			// failed reload just leaves the flag at its cleared value
			if (ldr_overflow && state_q == ST_RLD)
				ovf_q <= 1'b1; // RL9
			else if (start_ld)
				ovf_q <= 1'b0; // RL10
		end
	end

	// interrupt status clears on read, set wins over the read
	wire [3:0] iev = {ldr_overflow && (state_q == ST_RLD), ev_loaded,
		ev_tmo, ev_done};

	always @(posedge clk) begin
		if (rst) begin
			istat_q <= 4'h0;
			imask_q <= `SECP_RST_MASK;
			irq     <= 1'b0;
		end else begin
			istat_q <= (rd_istat ? 4'h0 : istat_q) | iev;
			if (wr_mask)
				imask_q <= reg_wdata[3:0];
			irq <= |(istat_q & imask_q);
		end
	end

	// read data stand in the cycle after the strobe only
	always @(posedge clk) begin
		if (rst)
			reg_rdata <= 32'h00000000;
		else if (reg_rd) begin
			if (sel(reg_addr, `SECP_OFF_CMD))
				reg_rdata <= {busy_q, cmd_q, 9'h000, ovf_q, tmo_q,
					loaded_q, addr_q};
			else if (sel(reg_addr, `SECP_OFF_DATA))
				reg_rdata <= {24'h000000, data_q}; // RL18
			else if (sel(reg_addr, `SECP_OFF_ISTAT))
				reg_rdata <= {28'h0000000, istat_q};
			else if (sel(reg_addr, `SECP_OFF_IMASK))
				reg_rdata <= {28'h0000000, imask_q};
			else
				reg_rdata <= 32'h00000000;
		end else
			reg_rdata <= 32'h00000000;
	end
endmodule // secp_eeprom_port

// File: rtl/secp_timer.v
// timeout counter used for the stretch, write and bus acquire limits
// assumes en is a same-clock level; dropping en restarts the count
`timescale 1ns/1ns
module secp_timer #(
	parameter W = 25,
	parameter [W-1:0] LIMIT = 25'd300000
) (
	input  wire         clk,
	input  wire         rst,
	input  wire         en,
	output reg          expired
);
	reg [W-1:0] cnt_q;

	// saturates at the limit so the pulse fires once per enabled stretch
	always @(posedge clk) begin
		if (rst || !en) begin
			cnt_q   <= {W{1'b0}};
			expired <= 1'b0;
		end else begin
			if (cnt_q != LIMIT)
				cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
			expired <= (cnt_q == LIMIT - {{(W-1){1'b0}}, 1'b1});
		end
	end
endmodule // secp_timer

// File: test/secp_eng_model.sv
// far-side model: serial bus engine and config loader
// assumes the port clock; knobs come from the bench
`timescale 1ns/1ns
module secp_eng_model (
	input wire        clk,
	input wire        eng_req,
	input wire        eng_write,
	input wire [15:0] eng_addr,
	input wire [7:0]  eng_wdata,
	input wire        ldr_start,
	input wire [7:0]  dly,
	input wire        absent,
	input wire        good,
	input wire        ovf,
	output reg        eng_gnt = 1'b0,
	output reg        eng_done = 1'b0,
	output reg [7:0]  eng_rdata = 8'h00,
	output reg        ldr_done = 1'b0,
	output reg        ldr_ok = 1'b0,
	output reg        ldr_overflow = 1'b0
);
	reg [7:0] mem [0:65535];
	reg [1:0] ph = 2'h0;
	reg [7:0] cnt = 8'h00;
	reg [3:0] lc = 4'h0;
	always @(posedge clk) begin
		eng_gnt <= 1'b0;
		eng_done <= 1'b0;
		ldr_done <= 1'b0;
		ldr_overflow <= 1'b0;
		ldr_ok <= ~ldr_ok;
		eng_rdata <= ~eng_rdata; // released lines never hold
		if (cnt != 8'h00)
			cnt <= cnt - 8'h01;
		else if (ph == 2'h0 && eng_req) begin
			ph <= 2'h1;
			cnt <= dly;
		end else if (ph == 2'h1) begin
			eng_gnt <= 1'b1;
			ph <= 2'h2;
			cnt <= dly;
		end else if (ph == 2'h2) begin
			ph <= 2'h0;
			eng_done <= !absent;
			eng_rdata <= mem[eng_addr];
			if (eng_write && !absent)
				mem[eng_addr] <= eng_wdata;
		end
		if (ldr_start)
			lc <= 4'h9;
		else if (lc != 4'h0) begin
			lc <= lc - 4'h1;
			ldr_overflow <= ovf && lc == 4'h5;
			if (lc == 4'h1) begin
				ldr_done <= 1'b1;
				ldr_ok <= good;
			end
		end
	end
endmodule // secp_eng_model

// File: test/secp_port_asserts.sv
// checker on the eeprom command port pins
// assumes the secp_eeprom_port ports, one clock
`timescale 1ns/1ns
module secp_chk (
	input wire        clk,
	input wire        rst,
	input wire [11:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire        reg_wr,
	input wire        reg_rd,
	input wire [31:0] reg_rdata,
	input wire        eng_req,
	input wire        eng_write,
	input wire [15:0] eng_addr,
	input wire        eng_gnt,
	input wire        ldr_start,
	input wire        ldr_done,
	input wire        dev_ready
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_go;
		reg_wr && reg_addr == 12'h1B4 && reg_wdata[31];
	endsequence
	property p_rd_go;
		s_go ##0 reg_wdata[30:28] == 3'h0 |=> eng_req && !eng_write
			&& eng_addr == $past(reg_wdata[15:0]);
	endproperty
	a_rd_go: assert property (p_rd_go) else $error("no read start");
	property p_reload;
		s_go ##0 reg_wdata[30:28] == 3'h7 |=> ldr_start ##1 !ldr_start
			&& !dev_ready;
	endproperty
	a_reload: assert property (p_reload) else $error("reload");
	property p_start;
		$rose(eng_req) |-> $past(reg_wr) && $past(reg_wdata[31]);
	endproperty
	a_start: assert property (p_start) else $error("stray req");
	property p_hold;
		eng_req && !eng_gnt |=> $stable(eng_addr) && $stable(eng_write);
	endproperty
	a_hold: assert property (p_hold) else $error("op moved");
	property p_gnt;
		eng_req && eng_gnt |=> !eng_req;
	endproperty
	a_gnt: assert property (p_gnt) else $error("req after gnt");
	property p_rdy_wait;
		!dev_ready && !ldr_done |=> !dev_ready;
	endproperty
	a_rdy_wait: assert property (p_rdy_wait) else $error("early ready");
	property p_rdy_end;
		!dev_ready && ldr_done |=> dev_ready;
	endproperty
	a_rdy_end: assert property (p_rdy_end) else $error("ready late");
	property p_data_hi;
		reg_rd && reg_addr == 12'h1B8 |=> reg_rdata[31:8] == 24'h000000;
	endproperty
	a_data_hi: assert property (p_data_hi) else $error("data hi");
endmodule // secp_chk
bind secp_eeprom_port secp_chk secp_chk_inst (
	.clk       (clk),
	.rst       (rst),
	.reg_addr  (reg_addr),
	.reg_wdata (reg_wdata),
	.reg_wr    (reg_wr),
	.reg_rd    (reg_rd),
	.reg_rdata (reg_rdata),
	.eng_req   (eng_req),
	.eng_write (eng_write),
	.eng_addr  (eng_addr),
	.eng_gnt   (eng_gnt),
	.ldr_start (ldr_start),
	.ldr_done  (ldr_done),
	.dev_ready (dev_ready)
);

// File: test/tb.sv
// self-checking bench for the eeprom command port
// assumes the model and checker files compile first
`timescale 1ns/1ns
module tb;
	localparam [11:0] CMD = 12'h1B4;
	localparam [11:0] DAT = 12'h1B8;
	localparam [11:0] IST = 12'h1BC;
	localparam [11:0] MSK = 12'h1C0;
	reg         clk = 1'b0;
	reg         rst = 1'b1;
	reg  [11:0] reg_addr = 12'h000;
	reg  [31:0] reg_wdata = 32'h0;
	reg         reg_wr = 1'b0;
	reg         reg_rd = 1'b0;
	reg         eng_nack = 1'b0;
	reg         eng_scl_low = 1'b0;
	reg  [7:0]  dly = 8'h02;
	reg         absent = 1'b0;
	reg         good = 1'b1;
	reg         ovf = 1'b0;
	wire [31:0] reg_rdata;
	wire        irq, eng_req, eng_write, eng_gnt, eng_done, ldr_start;
	wire        ldr_done, ldr_ok, ldr_overflow, dev_ready;
	wire [15:0] eng_addr;
	wire [7:0]  eng_wdata, eng_rdata;
	reg  [31:0] q;
	reg  [23:0] rows [0:3];
	integer     miscompares = 0;
	integer     n_checks = 0;
	integer     cyc = 0;
	integer     i;
	// short timeouts keep the run small
	secp_eeprom_port #(
		.T_WR_CYC  (25'd20),
		.T_ACQ_CYC (25'd40)
	) secp_eeprom_port_inst (
		.clk          (clk),
		.rst          (rst),
		.reg_addr     (reg_addr),
		.reg_wdata    (reg_wdata),
		.reg_wr       (reg_wr),
		.reg_rd       (reg_rd),
		.reg_rdata    (reg_rdata),
		.irq          (irq),
		.eng_req      (eng_req),
		.eng_write    (eng_write),
		.eng_addr     (eng_addr),
		.eng_wdata    (eng_wdata),
		.eng_gnt      (eng_gnt),
		.eng_done     (eng_done),
		.eng_nack     (eng_nack),
		.eng_scl_low  (eng_scl_low),
		.eng_rdata    (eng_rdata),
		.ldr_start    (ldr_start),
		.ldr_done     (ldr_done),
		.ldr_ok       (ldr_ok),
		.ldr_overflow (ldr_overflow),
		.dev_ready    (dev_ready)
	);
	secp_eng_model secp_eng_model_inst (
		.clk          (clk),
		.eng_req      (eng_req),
		.eng_write    (eng_write),
		.eng_addr     (eng_addr),
		.eng_wdata    (eng_wdata),
		.ldr_start    (ldr_start),
		.dly          (dly),
		.absent       (absent),
		.good         (good),
		.ovf          (ovf),
		.eng_gnt      (eng_gnt),
		.eng_done     (eng_done),
		.eng_rdata    (eng_rdata),
		.ldr_done     (ldr_done),
		.ldr_ok       (ldr_ok),
		.ldr_overflow (ldr_overflow)
	);
	initial forever #50 clk = ~clk;
	task stop_test;
		begin
			if (miscompares == 0 && n_checks > 0)
				$display("*** PASS ***");
			else
				$display("*** FAIL ***");
			$finish;
		end
	endtask
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			miscompares = miscompares + 1;
			stop_test;
		end
	end
	task chk(input [31:0] s, input [31:0] e);
		begin
			n_checks = n_checks + 1;
			if (s !== e) begin
				miscompares = miscompares + 1;
				$display("Error %0t: got %h want %h", $time, s, e);
			end
		end
	endtask
	task wr(input [11:0] a, input [31:0] d);
		begin
			@(posedge clk);
			reg_addr <= a;
			reg_wdata <= d;
			reg_wr <= 1'b1;
			@(posedge clk);
			reg_wr <= 1'b0;
		end
	endtask
	task rd(input [11:0] a);
		begin
			@(posedge clk);
			reg_addr <= a;
			reg_rd <= 1'b1;
			@(posedge clk);
			reg_rd <= 1'b0;
			// data stand for one cycle only; take them at its closing edge
			@(posedge clk);
			q = reg_rdata;
		end
	endtask
	task op(input [2:0] c, input [15:0] a);
		begin
			wr(CMD, {1'b1, c, 12'h000, a});
			rd(CMD);
			while (q[31] !== 1'b0)
				rd(CMD);
		end
	endtask
	initial begin
		rows[0] = 24'h0000A5;
		rows[1] = 24'h00FF3C;
		rows[2] = 24'h123400;
		rows[3] = 24'hFFFFFF;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		rd(CMD);
		chk(q, 32'h0);
		rd(DAT);
		chk(q, 32'h0);
		rd(12'h100);
		chk(q, 32'h0);
		wr(MSK, 32'h1);
		for (i = 0; i < 4; i = i + 1) begin
			wr(DAT, {24'hFFFFFF, rows[i][7:0]});
			op(3'h3, rows[i][23:8]);
			wr(DAT, 32'h0);
			op(3'h0, rows[i][23:8]);
			rd(DAT);
			chk(q, {24'h0, rows[i][7:0]});
			rd(CMD);
			chk(q, {16'h0, rows[i][23:8]});
		end
		chk(irq, 1'b1);
		rd(IST);
		chk(q, 32'h1);
		repeat (2) @(posedge clk);
		chk(irq, 1'b0);
		wr(MSK, 32'h0);
		// long enough that a counted read would time out
		dly <= 8'h1E;
		wr(CMD, 32'h80000000);
		wr(DAT, 32'h77); // refused while busy
		op(3'h0, 16'h0000);
		rd(DAT);
		chk(q, 32'hA5);
		eng_scl_low <= 1'b1;
		op(3'h0, 16'h00FF);
		chk(q, 32'h000200FF);
		eng_scl_low <= 1'b0;
		wr(CMD, 32'h20000);
		dly <= 8'h02;
		for (i = 1; i < 7; i = i + 1)
			if (i != 3) begin
				wr(CMD, {1'b1, i[2:0], 28'h0});
				wr(CMD, 32'h0);
				rd(CMD);
				chk(q, 32'h20000);
				wr(CMD, 32'h20000);
				rd(CMD);
				chk(q, 32'h0);
			end
		chk(irq, 1'b0);
		wr(MSK, 32'h2);
		repeat (2) @(posedge clk);
		chk(irq, 1'b1);
		absent <= 1'b1;
		op(3'h3, 16'h0010);
		chk(q, 32'h30020010);
		absent <= 1'b0;
		wr(CMD, 32'h20000);
		eng_nack <= 1'b1;
		op(3'h0, 16'h00FF);
		chk(q, 32'h000200FF);
		eng_nack <= 1'b0;
		rd(DAT);
		chk(q, 32'hA5);
		wr(CMD, 32'h20000);
		ovf <= 1'b1;
		op(3'h7, 16'h0000);
		chk(q, 32'h70050000);
		wr(CMD, 32'h10000);
		rd(CMD);
		chk(q, 32'h40000);
		ovf <= 1'b0;
		op(3'h7, 16'h0000);
		chk(q, 32'h70010000);
		good <= 1'b0;
		op(3'h7, 16'h0000);
		chk(q, 32'h70000000);
		good <= 1'b1;
		op(3'h7, 16'h0000);
		chk(dev_ready, 1'b1);
		chk(q, 32'h70010000);
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd(CMD);
		chk(q, 32'h0);
		dly <= 8'd60;
		op(3'h0, 16'h0000);
		chk(q, 32'h20000);
		stop_test;
	end
endmodule // tb
